// ==== hdl/adc_phase_pkg.sv ====
// Constants for the converter control block: register selects,
// field layouts, values after reset and timing divisors.
// Assumes a single core clock acting as the master clock.

package adc_phase_pkg;

  // ************************************************************
  // Widths
  // ************************************************************
  localparam int PHASE_W  = 12;
  localparam int CFG0_W   = 24;
  localparam int CFG1_W   = 8;
  localparam int CODE_W   = 24;
  localparam int REF_W    = 16;
  localparam int OSRLEN_W = 13;

  // ************************************************************
  // Register selects on the internal write port
  // ************************************************************
  localparam logic [1:0] SEL_CFG0  = 2'h0;
  localparam logic [1:0] SEL_CFG1  = 2'h1;
  localparam logic [1:0] SEL_PHASE = 2'h2;

  // ************************************************************
  // Field positions and reset values
  // ************************************************************
  localparam int TRIM_LSB = 0;
  localparam int TRIM_MSB = 7;
  localparam int REFSEL_BIT = 0;
  localparam int OSR_LSB  = 1;
  localparam int OSR_MSB  = 3;
  localparam int PRE_LSB  = 4;
  localparam int PRE_MSB  = 5;
  localparam logic [CFG0_W-1:0]  CFG0_RESET  = 24'h00_0050;
  localparam logic [CFG1_W-1:0]  CFG1_RESET  = 8'h06;
  localparam logic [PHASE_W-1:0] PHASE_RESET = 12'h000;
  localparam logic [3:0]         MOD_RESET_PATTERN = 4'h3;
  localparam logic [REF_W-1:0]   INT_REF_CODE = 16'h4000;

  // ************************************************************
  // Timing: core clocks per modulator clock at prescaler zero
  // ************************************************************
  localparam logic [7:0] MODULATOR_DIGITAL_CLOCK_DIV = 8'h04;
  localparam logic [OSRLEN_W-1:0] OSR_MIN = 13'h0020;

  // ************************************************************
  // Sequencer states
  // ************************************************************
  typedef enum logic [1:0] {
    ST_RESET   = 2'b00,
    ST_DELAY   = 2'b01,
    ST_CONVERT = 2'b10
  } seq_state_t;

endpackage

// ==== hdl/adc_phase_delay_reset_ctrl.sv ====
// Control logic around one delta-sigma channel: reference select,
// tempco trim, hard reset, phase delay and data-ready pulses.
// Assumes the serial decoder runs on core_clk; the hard reset pin is
// asynchronous and is synchronised here.
//
// Notes on behaviour
// - Reference select set: reference value is positive pin minus negative.
// - Trim field sits in bits 7..0 of first config word, reset 0x50.
// - After power-on, ready pulses run on defaults without host setup.
// - Hard reset pin low holds converter reset, output code zero.
// - Hard reset clears modulator state, comparator pattern forced 0011.
// - Hard reset clears filter, both buffers and all registers.
// - Serial writes are ignored while the hard reset pin is low.
// - Data output and ready output float while hard reset is low.
// - Twelve-bit signed phase code, offset half the ratio.
// - Delay equals phase code plus half ratio, modulator clock periods.
// - Delay counts prescaled clock ticks; ready timing follows it.
// - Effective delay limited to zero through ratio minus one.
// - Sign bit position tracks the ratio, bit 11 down to bit 4.
// - Code written at ratio 4096 adapts when the ratio changes.
// - Any phase write resets and restarts conversion, same value too.
// - At ratio 4096: 0x800 zero, 0x000 half, 0x7FF full delay.
// - Ready pin pulses each time new channel data is available.

`timescale 1ns/10ps
`default_nettype none

module adc_phase_delay_reset_ctrl (
  input  wire logic                                core_clk,      // Core
  input  wire logic                                rstn,          // POR
  input  wire logic                                hardResetN,    // Pin
  input  wire logic                                regWrEn,       // Write
  input  wire logic [1:0]                          regSel,        // Select
  input  wire logic [adc_phase_pkg::CFG0_W-1:0]    regWrData,     // Data
  input  wire logic [adc_phase_pkg::CODE_W-1:0]    filterSample,  // Filter
  input  wire logic [adc_phase_pkg::REF_W-1:0]     refPosCode,    // Ref +
  input  wire logic [adc_phase_pkg::REF_W-1:0]     refNegCode,    // Ref -
  input  wire logic                                sdoData,       // Serial
  input  wire logic                                sdoEnable,     // Serial
  output logic [adc_phase_pkg::CFG0_W-1:0]         cfg0Q,         // Readback
  output logic [adc_phase_pkg::CFG1_W-1:0]         cfg1Q,         // Readback
  output logic [adc_phase_pkg::PHASE_W-1:0]        phaseQ,        // Readback
  output logic [1:0]                               seqStateQ,     // Status
  output logic [adc_phase_pkg::CODE_W-1:0]         outputCodeQ,   // Data
  output logic [adc_phase_pkg::REF_W-1:0]          refValueQ,     // Ref
  output logic [3:0]                               modPatternQ,   // Mod
  output logic                                     convStartQ,    // Go
  output logic                                     readyNOut,     // Pin
  output logic                                     readyNOe,      // Pin
  output logic                                     sdoOut,        // Pin
  output logic                                     sdoOe          // Pin
);
  import adc_phase_pkg::*;

  // ************************************************************
  // Decode helpers
  // ************************************************************

  // Delay, code plus half ratio, equals the low field with its sign flipped
  function automatic logic [PHASE_W-1:0] effDelay(
    input logic [PHASE_W-1:0] code,
    input logic [2:0]         oversampling_ratio
  );
    logic [PHASE_W-1:0] mask;
    logic [PHASE_W-1:0] sbit;
    mask = 12'h0fff >> (3'h7 - oversampling_ratio);
    sbit = 12'h0010 << oversampling_ratio;
    return (code & mask) ^ sbit;
  endfunction

  // Conversion length in modulator clock periods
  function automatic logic [OSRLEN_W-1:0] osrLen(input logic [2:0] oversampling_ratio);
    return OSR_MIN << oversampling_ratio;
  endfunction

  // ************************************************************
  // Hard reset pin synchroniser
  // ************************************************************
  logic hrMeta_q;
  logic hrSync_q;

  // Two flops; only the second is read by logic
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      hrMeta_q <= 1'b0;
      hrSync_q <= 1'b0;
    end else begin
      hrMeta_q <= hardResetN;
      hrSync_q <= hrMeta_q;
    end
  end

  logic inReset;
  logic phaseWrite;
  assign inReset    = !rstn || !hrSync_q;
  assign phaseWrite = regWrEn && (regSel == SEL_PHASE);

  // ************************************************************
  // Configuration registers
  // ************************************************************

  // Reset branch wins, so writes during hard reset are lost
  always_ff @(posedge core_clk) begin
    if (inReset) begin
      cfg0Q  <= CFG0_RESET;
      cfg1Q  <= CFG1_RESET;
      phaseQ <= PHASE_RESET;
    end else if (regWrEn) begin
      case (regSel)
        SEL_CFG0:  cfg0Q  <= regWrData;
        SEL_CFG1:  cfg1Q  <= regWrData[CFG1_W-1:0];
        SEL_PHASE: phaseQ <= regWrData[PHASE_W-1:0];
        default: ;
      endcase
    end
  end

  logic [2:0] osrSel;
  logic [1:0] preSel;
  logic       refSel;
  assign osrSel = cfg1Q[OSR_MSB:OSR_LSB];
  assign preSel = cfg1Q[PRE_MSB:PRE_LSB];
  assign refSel = cfg1Q[REFSEL_BIT];

  // ************************************************************
  // Reference value
  // ************************************************************

  // Differential mode subtracts the negative pin reading
  always_ff @(posedge core_clk) begin
    if (inReset) begin
      refValueQ <= INT_REF_CODE;
    end else if (refSel) begin
      refValueQ <= refPosCode - refNegCode;
    end else begin
      refValueQ <= INT_REF_CODE;
    end
  end

  // ************************************************************
  // Modulator clock tick from the prescaled master clock
  // ************************************************************
  logic [7:0] preCnt_q;
  logic [7:0] prePeriod;
  logic       dmTick;
  assign prePeriod = MODULATOR_DIGITAL_CLOCK_DIV << preSel;
  assign dmTick    = (preCnt_q >= prePeriod - 8'h01);

  // Prescaler change alters every downstream delay
  always_ff @(posedge core_clk) begin
    if (inReset || phaseWrite || dmTick) begin
      preCnt_q <= 8'h00;
    end else begin
      preCnt_q <= preCnt_q + 8'h01;
    end
  end

  // ************************************************************
  // Phase delay and conversion sequencer
  // ************************************************************
  seq_state_t         state_q;
  logic [PHASE_W-1:0]  delayCnt_q;
  logic [OSRLEN_W-1:0] convCnt_q;
  logic [PHASE_W-1:0]  delayTarget;
  logic [OSRLEN_W-1:0] convLast;
  logic                convDone;
  assign delayTarget = effDelay(phaseQ, osrSel);
  assign convLast    = osrLen(osrSel) - 13'h0001;
  assign convDone    = (state_q == ST_CONVERT) && dmTick
                       && (convCnt_q >= convLast);
  assign seqStateQ   = state_q;

  // Restart on any phase write, even an unchanged value
  always_ff @(posedge core_clk) begin
    if (inReset) begin
      state_q <= ST_RESET;
    end else if (phaseWrite) begin
      state_q <= ST_DELAY;
    end else begin
      case (state_q)
        ST_RESET: state_q <= ST_DELAY;
        ST_DELAY: begin
          if (dmTick && delayCnt_q >= delayTarget) begin
            state_q <= ST_CONVERT;
          end
        end
        ST_CONVERT: state_q <= ST_CONVERT;
        default: state_q <= ST_RESET;
      endcase
    end
  end

  // Delay counter starts from zero after every restart cause
  always_ff @(posedge core_clk) begin
    if (inReset || phaseWrite || state_q != ST_DELAY) begin
      delayCnt_q <= '0;
    end else if (dmTick && delayCnt_q < delayTarget) begin
      delayCnt_q <= delayCnt_q + 12'h001;
    end
  end

  // Conversion period counter; a shortened ratio ends at the next tick
  always_ff @(posedge core_clk) begin
    if (inReset || phaseWrite || state_q != ST_CONVERT) begin
      convCnt_q <= '0;
    end else if (dmTick) begin
      convCnt_q <= convDone ? 13'h0000 : convCnt_q + 13'h0001;
    end
  end

  // One-cycle marker of the first released conversion
  always_ff @(posedge core_clk) begin
    if (inReset || phaseWrite) begin
      convStartQ <= 1'b0;
    end else begin
      convStartQ <= (state_q == ST_DELAY) && dmTick
                    && (delayCnt_q >= delayTarget);
    end
  end

  // ************************************************************
  // Modulator state and filter output buffers
  // ************************************************************
  logic [CODE_W-1:0] filtBuf_q;

  // Pattern stays forced until conversion is running
  always_ff @(posedge core_clk) begin
    if (inReset || phaseWrite || state_q != ST_CONVERT) begin
      modPatternQ <= MOD_RESET_PATTERN;
    end else begin
      modPatternQ <= filterSample[3:0];
    end
  end

  // Double buffer: capture stage then presented code
  always_ff @(posedge core_clk) begin
    if (inReset || phaseWrite) begin
      filtBuf_q   <= '0;
      outputCodeQ <= '0;
    end else begin
      if (convDone) begin
        filtBuf_q <= filterSample;
      end
      outputCodeQ <= filtBuf_q;
    end
  end

  // ************************************************************
  // Pins: ready pulse and serial output
  // ************************************************************
  logic readyPend_q;

  // Code lands one cycle after capture; pulse aligns with it
  always_ff @(posedge core_clk) begin
    if (inReset || phaseWrite) begin
      readyPend_q <= 1'b0;
      readyNOut   <= 1'b1;
    end else begin
      readyPend_q <= convDone;
      readyNOut   <= !readyPend_q;
    end
  end

  // Both outputs float during either reset
  always_ff @(posedge core_clk) begin
    if (inReset) begin
      readyNOe <= 1'b0;
      sdoOe    <= 1'b0;
      sdoOut   <= 1'b0;
    end else begin
      readyNOe <= 1'b1;
      sdoOe    <= sdoEnable;
      sdoOut   <= sdoData;
    end
  end

  // ************************************************************
  // Checks
  // ************************************************************
  default clocking cb @(posedge core_clk); endclocking

  sequence s_readyPulse;
    !readyNOut ##1 readyNOut;
  endsequence

  sequence s_restarted;
    (state_q == ST_DELAY) && (delayCnt_q == '0);
  endsequence

  chk_trim_default: assert property (
    !rstn |=> cfg0Q[TRIM_MSB:TRIM_LSB] == 8'h50)
    else $error("trim field not at default after reset");

  chk_code_zero: assert property (
    inReset |=> outputCodeQ == '0)
    else $error("output code not zero in reset");

  chk_mod_pattern: assert property (
    inReset |=> modPatternQ == 4'b0011)
    else $error("modulator pattern not forced in reset");

  chk_write_ignored: assert property (
    (rstn && !hrSync_q && regWrEn) |=> phaseQ == PHASE_RESET)
    else $error("write took effect during hard reset");

  chk_pins_float: assert property (
    disable iff (!rstn) !hrSync_q |=> !readyNOe && !sdoOe)
    else $error("outputs driven during hard reset");

  chk_phase_restart: assert property (
    disable iff (inReset) phaseWrite |=> s_restarted)
    else $error("phase write did not restart");

  chk_delay_limit: assert property (
    disable iff (inReset)
    state_q == ST_DELAY |-> delayTarget <= convLast[PHASE_W-1:0])
    else $error("effective delay beyond ratio");

  chk_first_release: assert property (
    disable iff (inReset || phaseWrite)
    (state_q == ST_DELAY && dmTick && delayCnt_q >= delayTarget)
      |=> state_q == ST_CONVERT && convStartQ)
    else $error("conversion not released after delay");

  chk_ready_pulse: assert property (
    disable iff (inReset || phaseWrite)
    convDone |=> ##1 s_readyPulse)
    else $error("ready pulse missing after conversion");

  chk_ref_diff: assert property (
    disable iff (inReset)
    (refSel && $past(refSel)) |-> refValueQ ==
      $past(refPosCode) - $past(refNegCode))
    else $error("differential reference wrong");

endmodule

`default_nettype wire

// ==== dv/adc_phase_host_model.sv ====
// Host model: writes registers and collects ready pulses.
// Assumes a pull-up on the ready pin while the device floats it.
`timescale 1ns/10ps
`default_nettype none
module adc_phase_host_model #(
  parameter int IGNORE_CYC = 64
) (
  input  wire logic        clk,        // Core clock
  input  wire logic        rstn,       // Reset
  input  wire logic        readyNOut,  // Ready level
  input  wire logic        readyNOe,   // Ready enable
  input  wire logic [23:0] outputCode, // Data
  output logic             regWrEn,    // Strobe
  output logic [1:0]       regSel,     // Select
  output logic [23:0]      regWrData   // Data
);
  logic        readyPin;
  int          sinceRst;
  int          pulseCount;
  logic [23:0] lastCode;
  // Pull-up wins while the pin floats
  assign readyPin = readyNOe ? readyNOut : 1'b1;
  // Early pulses carry unsettled data, so they are dropped
  always @(posedge clk) begin
    if (!rstn) begin
      sinceRst <= 0;
      pulseCount <= 0;
    end else begin
      sinceRst <= sinceRst + 1;
      if (readyPin === 1'b0 && sinceRst >= IGNORE_CYC) begin
        pulseCount <= pulseCount + 1;
        lastCode <= outputCode;
      end
    end
  end
  // One write: held across the taking edge, then dropped
  task automatic wr(input logic [1:0] sel, input logic [23:0] d);
    @(posedge clk);
    #1;
    regWrEn = 1'b1;
    regSel = sel;
    regWrData = d;
    @(posedge clk);
    #1;
    regWrEn = 1'b0;
  endtask
  initial begin
    regWrEn = 1'b0;
    regSel = 2'h3;
    regWrData = 24'h00_0000;
  end
endmodule
`default_nettype wire

// ==== dv/adc_phase_delay_reset_ctrl_bench.sv ====
// Bench for the converter control block with a host model.
// Assumes a 20 MHz core clock and default prescaler timing.
`timescale 1ns/10ps
`default_nettype none
module adc_phase_delay_reset_ctrl_bench;
  import adc_phase_pkg::*;
  typedef struct {logic [7:0] cfg1; logic [11:0] phase; int dly;} row_t;
  logic core_clk = 1'b0;
  logic rstn = 1'b0;
  logic hardResetN = 1'b1;
  logic regWrEn, sdoData = 1'b1, sdoEnable = 1'b1;
  logic [1:0] regSel;
  logic [23:0] regWrData, cfg0Q, outputCodeQ;
  logic [23:0] filterSample = 24'hA5_5A3C;
  logic [15:0] refPosCode = 16'h5000, refNegCode = 16'h0800, refValueQ;
  logic [7:0] cfg1Q;
  logic [11:0] phaseQ;
  logic [1:0] seqStateQ;
  logic [3:0] modPatternQ;
  logic convStartQ, readyNOut, readyNOe, sdoOut, sdoOe;
  int failCount = 0, checkCount = 0, lat, tick;
  row_t rows[16] = '{'{8'h00, 12'h010, 0}, '{8'h00, 12'h000, 16},
    '{8'h00, 12'h000, 16}, '{8'h00, 12'h00F, 31}, '{8'h00, 12'h01F, 15},
    '{8'h00, 12'h7F0, 0}, '{8'h10, 12'h000, 16}, '{8'h06, 12'h080, 0},
    '{8'h06, 12'h07F, 255}, '{8'h0E, 12'h800, 0}, '{8'h0E, 12'h000, 2048},
    '{8'h0E, 12'h7FF, 4095}, '{8'h02, 12'h7FF, 31},
    '{8'h2A, 12'h000, 512}, '{8'h38, 12'h0FF, 511},
    '{8'h0C, 12'h3FF, 2047}};
  // ****************************************
  // Clock, device and host
  // ****************************************
  always #25 core_clk = ~core_clk;
  adc_phase_delay_reset_ctrl uut (.core_clk(core_clk), .rstn(rstn),
    .hardResetN(hardResetN), .regWrEn(regWrEn), .regSel(regSel),
    .regWrData(regWrData), .filterSample(filterSample),
    .refPosCode(refPosCode), .refNegCode(refNegCode), .sdoData(sdoData),
    .sdoEnable(sdoEnable), .cfg0Q(cfg0Q), .cfg1Q(cfg1Q), .phaseQ(phaseQ),
    .seqStateQ(seqStateQ), .outputCodeQ(outputCodeQ),
    .refValueQ(refValueQ), .modPatternQ(modPatternQ),
    .convStartQ(convStartQ), .readyNOut(readyNOut), .readyNOe(readyNOe),
    .sdoOut(sdoOut), .sdoOe(sdoOe));
  adc_phase_host_model #(.IGNORE_CYC(200)) host (.clk(core_clk),
    .rstn(rstn), .readyNOut(readyNOut), .readyNOe(readyNOe),
    .outputCode(outputCodeQ), .regWrEn(regWrEn), .regSel(regSel),
    .regWrData(regWrData));
  // ****************************************
  // Helpers
  // ****************************************
  task automatic check(input logic [31:0] seen, input logic [31:0] expv);
    checkCount++;
    if (seen !== expv) begin
      failCount++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, expv);
    end
  endtask
  task automatic stopTest();
    $display("checks=%0d mismatches=%0d", checkCount, failCount);
    if (failCount == 0 && checkCount > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  // Bounded wait for a start pulse or a ready pulse
  task automatic waitEv(input bit useReady, output int n);
    n = 0;
    do begin
      cyc(1);
      n++;
    end while (!(useReady ? readyNOut === 1'b0 : convStartQ === 1'b1)
               && n < 20000);
    if (n >= 20000) begin
      failCount++;
      stopTest();
    end
  endtask
  // ****************************************
  // Sequence
  // ****************************************
  initial begin
    cyc(2);
    rstn = 1'b1;
    cyc(4);
    // Start pulse lands (delay + 1) ticks after the write edge
    for (int i = 0; i < 16; i++) begin
      host.wr(SEL_CFG1, {16'h0000, rows[i].cfg1});
      host.wr(SEL_PHASE, {12'h000, rows[i].phase});
      cyc(1);
      check(phaseQ, rows[i].phase);
      waitEv(1'b0, lat);
      tick = 4 << rows[i].cfg1[5:4];
      check(lat, (rows[i].dly+1)*tick-1);
    end
    // Reference source select
    host.wr(SEL_CFG1, 24'h00_0001);
    cyc(2);
    check(refValueQ, 16'h4800);
    host.wr(SEL_CFG1, 24'h00_0000);
    cyc(2);
    check(refValueQ, INT_REF_CODE);
    // Hard reset drops a prior trim and refuses writes
    host.wr(SEL_CFG0, 24'h00_0042);
    cyc(1);
    check(cfg0Q, 24'h00_0042);
    check({sdoOut, sdoOe}, 2'b11);
    hardResetN = 1'b0;
    cyc(3);
    check({readyNOe, sdoOe}, 2'b00);
    check(outputCodeQ, 24'h00_0000);
    check(modPatternQ, MOD_RESET_PATTERN);
    check(cfg0Q, CFG0_RESET);
    check(seqStateQ, ST_RESET);
    host.wr(SEL_PHASE, 24'h00_0005);
    cyc(1);
    check(phaseQ, 12'h000);
    hardResetN = 1'b1;
    cyc(4);
    check(phaseQ, PHASE_RESET);
    check({readyNOe, sdoOe}, 2'b11);
    // Second power-on reset: ready pulses on defaults alone
    rstn = 1'b0;
    cyc(2);
    rstn = 1'b1;
    cyc(3);
    check(cfg0Q, 24'h00_0050);
    check(cfg1Q, CFG1_RESET);
    waitEv(1'b1, lat);
    check(outputCodeQ, filterSample);
    cyc(1);
    check(readyNOut, 1'b1);
    waitEv(1'b1, lat);
    check(lat + 1, 256 * 4);
    check(host.pulseCount != 0, 1'b1);
    check(host.lastCode, filterSample);
    stopTest();
  end
endmodule
`default_nettype wire
